/* File: common/pmc_regs.vh */
// register offsets, field positions, reset values and timing counts of the power mode controller
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PMC_OFS_OPERATING_MODE 12'h000
`define PMC_OFS_CPU_CONTROL 12'h004
`define PMC_OFS_IO_CONTROL 12'h008
`define PMC_OFS_COMMAND 12'h00C
`define PMC_OFS_STATUS 12'h010
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PMC_BIT_FSE 7
`define PMC_BIT_TFSE 6
`define PMC_BIT_IOC 5
`define PMC_BIT_QUICK 3
`define PMC_BIT_EXTGRANT 5
`define PMC_BIT_STBYSEL 6
`define PMC_BIT_PSTOP 5
`define PMC_BIT_CMD_HALT 0
`define PMC_BIT_CMD_SLEEP 1
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PMC_RST_OPERATING_MODE 8'hE0
`define PMC_RST_CPU_CONTROL 8'h00
`define PMC_RST_IO_CONTROL 8'h00
// ------------------------------------------------------------
// timing counts (clocks)
// ------------------------------------------------------------
`define PMC_SLEEP_RESTART_CLKS 2
`define PMC_IDLE_RESTART_CLKS 10
`define PMC_IDLE_GRANT_EXTRA_CLKS 8
`define PMC_STBY_SLOW_CLKS 131072
`define PMC_STBY_QUICK_CLKS 64
// ------------------------------------------------------------
// mode codes
// ------------------------------------------------------------
`define PMC_MODE_NORMAL 3'h0
`define PMC_MODE_HALT 3'h1
`define PMC_MODE_SLEEP 3'h2
`define PMC_MODE_SYSSTOP 3'h3
`define PMC_MODE_IDLE 3'h4
`define PMC_MODE_STANDBY 3'h5
`endif

/* File: hdl/pmc_delay_counter.v */
// down counter that times restart and grant delays
`timescale 1ns/1ps
`default_nettype none
module pmc_delay_counter #(
	parameter WIDTH = 18
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire load_i,
	input wire [WIDTH-1:0] count_i,
	input wire abort_i,
	output reg busy_o,
	output reg done_o
);
	// remaining cycles
	reg [WIDTH-1:0] remain;
	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	// load starts, abort cancels, done pulses at terminal count
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			remain <= {WIDTH{1'b0}};
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else if (abort_i)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else if (load_i)
		begin
			remain <= count_i;
			busy_o <= 1'b1;
			done_o <= 1'b0;
		end
		else if (busy_o)
		begin
			// last step raises done
			if (remain <= {{(WIDTH-1){1'b0}}, 1'b1})
			begin
				busy_o <= 1'b0;
				done_o <= 1'b1;
			end
			else
			begin
				remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
				done_o <= 1'b0;
			end
		end
		else
		begin
			done_o <= 1'b0;
		end
	end
endmodule // pmc_delay_counter
`default_nettype wire

/* File: hdl/pmc_power_mode_ctrl.v */
// operating mode, low power sequencing and bus compatibility control over apb
// Notes on behaviour
// - temp fetch enable resets and reads one
// - writing zero forces strobe on next fetch
// - temp bit one leaves regular enable governing
// - io compat resets one, native io timing
// - compat zero: io strobes from t2 rise
// - normal mode runs, halt output high
// - halt: refetch, halt status strobe low
// - halt keeps clock, grants, refresh, peripherals
// - halt exits on reset, nmi, enabled interrupts
// - sleep with all select bits zero
// - sleep gates core and dma, stops refresh
// - sleep drives address and controls high
// - disabled sources don't wake; flag picks path
// - sleep restart about one and half clocks
// - peripheral stop halts serial and timers
// - system stop: stopped peripherals can't wake
// - idle blocks clock output and units
// - idle exits on external; about 9.5 clocks
// - idle grant eight clocks slower
// - request drop re-stops clock, stays idle
// - stop plus standby select enters standby
// - standby wakes/grants after oscillator settles
// - settle delay 131072 or 64 clocks
// - request drop before settle stays standby
// - fetch strobe on fetch and acknowledges
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_power_mode_ctrl #(
	parameter STBY_SLOW_CLKS = `PMC_STBY_SLOW_CLKS
) (
	input wire core_clk_i,
	input wire rst_n_i,
	// apb slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output reg [31:0] prdata_o,
	output wire pslverr_o,
	// core cycle indications
	input wire opcode_fetch_i,
	input wire int_ack_i,
	input wire nmi_ack_first_i,
	input wire io_cycle_i,
	input wire io_read_i,
	input wire io_t2_i,
	// wake sources from pins, synchronised here
	input wire nmi_n_i,
	input wire [2:0] external_interrupt_request_n_i,
	input wire bus_request_n_i,
	// wake qualifiers from the interrupt unit
	input wire [2:0] ext_int_enable_i,
	input wire onchip_int_i,
	input wire global_interrupt_flag_i,
	// mode and strobe outputs
	output reg [2:0] mode_o,
	output reg halt_n_o,
	output reg status_output_o,
	output reg fetch_cycle_strobe_n_o,
	output reg io_request_strobe_n_o,
	output reg io_read_strobe_n_o,
	output reg force_bus_high_o,
	output reg cpu_clk_en_o,
	output reg dma_clk_en_o,
	output reg periph_clk_en_o,
	output reg refresh_en_o,
	output reg system_clock_output_en_o,
	output reg osc_en_o,
	output reg bus_grant_o,
	output reg wake_service_o,
	output reg wake_resume_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam ST_RUN = 3'h0; // normal or halt
	localparam ST_SLEEP = 3'h1; // sleep or system stop
	localparam ST_IDLE = 3'h2; // idle
	localparam ST_STBY = 3'h3; // standby, oscillator off
	localparam ST_WAKE = 3'h4; // restart delay running
	localparam ST_GRANT = 3'h5; // bus granted while asleep
	localparam ST_SETTLE = 3'h6; // standby oscillator settling or idle grant delay
	reg [2:0] state;
	reg [2:0] sleep_kind; // mode asleep in
	reg [2:0] next_mode_sel; // decoded sleep target
	reg settle_for_grant; // settle leads to grant
	// registers
	reg fetch_strobe_enable;
	reg temp_fetch_strobe_enable; // pending one-shot, active high
	reg io_timing_compat;
	reg quick_recovery_select;
	reg external_grant_when_asleep;
	reg standby_select;
	reg peripheral_stop;
	reg halted;
	// synchronisers
	reg [4:0] pin_meta;
	reg [4:0] pin_sync;
	wire nmi_req = ~pin_sync[0];
	wire [2:0] ext_req = ~pin_sync[3:1] & ext_int_enable_i;
	wire bus_req = ~pin_sync[4];
	// delay counter
	reg cnt_load;
	reg [17:0] cnt_value;
	reg cnt_abort;
	// delay counts cut to counter width on purpose
	localparam [17:0] CNT_SLEEP = `PMC_SLEEP_RESTART_CLKS;
	localparam [17:0] CNT_IDLE = `PMC_IDLE_RESTART_CLKS;
	localparam [17:0] CNT_GRANT = `PMC_IDLE_GRANT_EXTRA_CLKS;
	localparam [17:0] CNT_QUICK = `PMC_STBY_QUICK_CLKS;
	localparam [17:0] CNT_SLOW = STBY_SLOW_CLKS;
	wire cnt_busy;
	wire cnt_done;
	// apb strobes
	wire apb_wr = psel_i & penable_i & pwrite_i;
	wire apb_rd_setup = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	// ------------------------------------------------------------
	// sleep target decode
	// ------------------------------------------------------------
	function [2:0] sleep_target;
		input stop_bit;
		input stby_bit;
		input quick_bit;
		begin
			if (!stop_bit)
				sleep_target = `PMC_MODE_SLEEP;
			else if (stby_bit)
				sleep_target = `PMC_MODE_STANDBY;
			else if (quick_bit)
				sleep_target = `PMC_MODE_IDLE;
			else
				sleep_target = `PMC_MODE_SYSSTOP;
		end
	endfunction
	always @*
	begin
		next_mode_sel = sleep_target(peripheral_stop, standby_select, quick_recovery_select);
	end
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta <= 5'h1F;
			pin_sync <= 5'h1F;
		end
		else
		begin
			pin_meta <= {bus_request_n_i, external_interrupt_request_n_i, nmi_n_i};
			pin_sync <= pin_meta;
		end
	end
	// ------------------------------------------------------------
	// apb register writes and commands
	// ------------------------------------------------------------
	wire cmd_halt = apb_wr && paddr_i == `PMC_OFS_COMMAND && pwdata_i[`PMC_BIT_CMD_HALT];
	wire cmd_sleep = apb_wr && paddr_i == `PMC_OFS_COMMAND && pwdata_i[`PMC_BIT_CMD_SLEEP];
	wire fetch_now = opcode_fetch_i & ~halted & (state == ST_RUN);
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			fetch_strobe_enable <= 1'b1;
			temp_fetch_strobe_enable <= 1'b0;
			io_timing_compat <= 1'b1;
			quick_recovery_select <= 1'b0;
			external_grant_when_asleep <= 1'b0;
			standby_select <= 1'b0;
			peripheral_stop <= 1'b0;
		end
		else
		begin
			// one-shot clears on the fetch it served, a new write wins
			if (apb_wr && paddr_i == `PMC_OFS_OPERATING_MODE)
			begin
				fetch_strobe_enable <= pwdata_i[`PMC_BIT_FSE];
				io_timing_compat <= pwdata_i[`PMC_BIT_IOC];
				temp_fetch_strobe_enable <= ~pwdata_i[`PMC_BIT_TFSE];
			end
			else if (fetch_now)
				temp_fetch_strobe_enable <= 1'b0;
			if (apb_wr && paddr_i == `PMC_OFS_CPU_CONTROL)
			begin
				quick_recovery_select <= pwdata_i[`PMC_BIT_QUICK];
				external_grant_when_asleep <= pwdata_i[`PMC_BIT_EXTGRANT];
				standby_select <= pwdata_i[`PMC_BIT_STBYSEL];
			end
			// peripheral stop is a plain level, cleared to resume
			if (apb_wr && paddr_i == `PMC_OFS_IO_CONTROL)
				peripheral_stop <= pwdata_i[`PMC_BIT_PSTOP];
		end
	end
	// ------------------------------------------------------------
	// apb read data, registered in setup phase
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			prdata_o <= 32'h0000_0000;
		else if (apb_rd_setup)
		begin
			case (paddr_i)
				`PMC_OFS_OPERATING_MODE:
					prdata_o <= {24'h00_0000, fetch_strobe_enable, 1'b1,
						io_timing_compat, 5'h00};
				`PMC_OFS_CPU_CONTROL:
					prdata_o <= {25'h000_0000, standby_select, external_grant_when_asleep,
						1'b0, quick_recovery_select, 3'h0};
				`PMC_OFS_IO_CONTROL:
					prdata_o <= {26'h000_0000, peripheral_stop, 5'h00};
				`PMC_OFS_STATUS:
					prdata_o <= {25'h000_0000, bus_grant_o, state, mode_o};
				default:
					prdata_o <= 32'h0000_0000;
			endcase
		end
	end
	// ------------------------------------------------------------
	// wake conditions per mode
	// ------------------------------------------------------------
	// disabled sources never wake; on-chip only in plain sleep or halt
	wire ext_wake = nmi_req | (|ext_req);
	wire any_wake = ext_wake | (onchip_int_i & (sleep_kind == `PMC_MODE_SLEEP));
	wire halt_wake = ext_wake | onchip_int_i;
	// ------------------------------------------------------------
	// mode sequencer
	// ------------------------------------------------------------
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_RUN;
			sleep_kind <= `PMC_MODE_NORMAL;
			halted <= 1'b0;
			settle_for_grant <= 1'b0;
			wake_service_o <= 1'b0;
			wake_resume_o <= 1'b0;
			cnt_load <= 1'b0;
			cnt_value <= 18'h0_0000;
			cnt_abort <= 1'b0;
		end
		else
		begin
			cnt_load <= 1'b0;
			cnt_abort <= 1'b0;
			wake_service_o <= 1'b0;
			wake_resume_o <= 1'b0;
			case (state)
				ST_RUN:
				begin
					if (halted && halt_wake)
					begin
						halted <= 1'b0;
						wake_service_o <= 1'b1;
					end
					else if (cmd_halt)
						halted <= 1'b1;
					else if (cmd_sleep)
					begin
						sleep_kind <= next_mode_sel;
						case (next_mode_sel)
							`PMC_MODE_IDLE: state <= ST_IDLE;
							`PMC_MODE_STANDBY: state <= ST_STBY;
							default: state <= ST_SLEEP;
						endcase
					end
				end
				ST_SLEEP:
				begin
					// short restart
					if (any_wake)
					begin
						cnt_value <= CNT_SLEEP;
						cnt_load <= 1'b1;
						state <= ST_WAKE;
					end
				end
				ST_IDLE:
				begin
					if (ext_wake)
					begin
						cnt_value <= CNT_IDLE;
						cnt_load <= 1'b1;
						state <= ST_WAKE;
					end
					else if (bus_req && external_grant_when_asleep)
					begin
						cnt_value <= CNT_GRANT;
						cnt_load <= 1'b1;
						settle_for_grant <= 1'b1;
						state <= ST_SETTLE;
					end
				end
				ST_STBY:
				begin
					// oscillator must settle before any answer
					if (ext_wake || (bus_req && external_grant_when_asleep))
					begin
						cnt_value <= quick_recovery_select ? CNT_QUICK
							: CNT_SLOW;
						cnt_load <= 1'b1;
						settle_for_grant <= ~ext_wake;
						state <= ST_SETTLE;
					end
				end
				ST_SETTLE:
				begin
					// request dropped early: back to sleep
					if (!(settle_for_grant ? bus_req : ext_wake))
					begin
						cnt_abort <= 1'b1;
						state <= (sleep_kind == `PMC_MODE_IDLE) ? ST_IDLE : ST_STBY;
					end
					else if (cnt_done)
						state <= settle_for_grant ? ST_GRANT : ST_WAKE;
				end
				ST_GRANT:
				begin
					// grant held until request drops
					if (!bus_req)
						state <= (sleep_kind == `PMC_MODE_IDLE) ? ST_IDLE : ST_STBY;
				end
				ST_WAKE:
				begin
					if (cnt_done || (!cnt_busy && !cnt_load))
					begin
						state <= ST_RUN;
						sleep_kind <= `PMC_MODE_NORMAL;
						wake_service_o <= global_interrupt_flag_i | nmi_req;
						wake_resume_o <= ~global_interrupt_flag_i & ~nmi_req;
					end
				end
				default:
					state <= ST_RUN;
			endcase
		end
	end
	// ------------------------------------------------------------
	// delay counter
	// ------------------------------------------------------------
	pmc_delay_counter #(
		.WIDTH(18)
	) u_delay (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(cnt_load),
		.count_i(cnt_value),
		.abort_i(cnt_abort),
		.busy_o(cnt_busy),
		.done_o(cnt_done)
	);
	// ------------------------------------------------------------
	// outputs: clock gates, bus state and strobes
	// ------------------------------------------------------------
	wire asleep = (state != ST_RUN) && (state != ST_WAKE);
	wire granted = (state == ST_GRANT);
	always @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			mode_o <= `PMC_MODE_NORMAL;
			halt_n_o <= 1'b1;
			status_output_o <= 1'b1;
			fetch_cycle_strobe_n_o <= 1'b1;
			io_request_strobe_n_o <= 1'b1;
			io_read_strobe_n_o <= 1'b1;
			force_bus_high_o <= 1'b0;
			cpu_clk_en_o <= 1'b1;
			dma_clk_en_o <= 1'b1;
			periph_clk_en_o <= 1'b1;
			refresh_en_o <= 1'b1;
			system_clock_output_en_o <= 1'b1;
			osc_en_o <= 1'b1;
			bus_grant_o <= 1'b0;
		end
		else
		begin
			mode_o <= asleep ? sleep_kind : (halted ? `PMC_MODE_HALT : `PMC_MODE_NORMAL);
			// halt low when halted or asleep, high in normal run
			halt_n_o <= ~(halted | asleep);
			// status held high while asleep, low only when halted
			status_output_o <= ~halted;
			force_bus_high_o <= asleep & ~granted;
			cpu_clk_en_o <= ~asleep;
			dma_clk_en_o <= ~asleep;
			periph_clk_en_o <= ~peripheral_stop &
				~(asleep && (sleep_kind == `PMC_MODE_IDLE || sleep_kind == `PMC_MODE_STANDBY));
			refresh_en_o <= ~asleep;
			// clock out runs in sleep, blocked in idle except while granting
			system_clock_output_en_o <= ~(asleep && (sleep_kind == `PMC_MODE_IDLE
				|| sleep_kind == `PMC_MODE_STANDBY) && !granted);
			osc_en_o <= ~(state == ST_STBY);
			bus_grant_o <= granted;
			// fetch strobe: halted fetches low, one-shot, or regular enable
			fetch_cycle_strobe_n_o <= ~((halted & opcode_fetch_i)
				| (fetch_now & temp_fetch_strobe_enable)
				| (fetch_strobe_enable & (fetch_now | int_ack_i | nmi_ack_first_i)));
			// compat zero raises strobes from t2, else native timing
			if (io_timing_compat)
			begin
				io_request_strobe_n_o <= ~io_cycle_i;
				io_read_strobe_n_o <= ~(io_cycle_i & io_read_i);
			end
			else
			begin
				io_request_strobe_n_o <= ~(io_cycle_i & io_t2_i);
				io_read_strobe_n_o <= ~(io_cycle_i & io_read_i & io_t2_i);
			end
		end
	end
endmodule // pmc_power_mode_ctrl
`default_nettype wire

/* File: test/pmc_far_side.sv */
// far side model: external bus master and interrupt request pins
`timescale 1ns/1ps
`default_nettype none
module pmc_far_side (
	input wire logic core_clk_i,
	input wire logic want_bus_i,
	input wire logic [2:0] want_irq_i,
	input wire logic want_nmi_i,
	output logic bus_request_n_o,
	output logic [2:0] irq_n_o,
	output logic nmi_n_o
);
	// -----------------------------
	// pin drivers
	// -----------------------------
	// pins idle high; released requests go back high on the next clock edge
	initial
	begin
		bus_request_n_o = 1'b1;
		irq_n_o = 3'h7;
		nmi_n_o = 1'b1;
	end
	// request dropped by master on the clock edge after bench lets go
	always @(posedge core_clk_i)
	begin
		bus_request_n_o <= !want_bus_i;
		irq_n_o <= ~want_irq_i;
		nmi_n_o <= !want_nmi_i;
	end
endmodule // pmc_far_side
`default_nettype wire

/* File: test/pmc_power_mode_ctrl_sva.sv */
// checker for mode outputs of the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_power_mode_ctrl_sva (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic nmi_n_i,
	input wire logic bus_request_n_i,
	input wire logic [2:0] mode_o,
	input wire logic halt_n_o,
	input wire logic status_output_o,
	input wire logic force_bus_high_o,
	input wire logic cpu_clk_en_o,
	input wire logic dma_clk_en_o,
	input wire logic periph_clk_en_o,
	input wire logic refresh_en_o,
	input wire logic system_clock_output_en_o,
	input wire logic osc_en_o,
	input wire logic bus_grant_o,
	input wire logic wake_service_o,
	input wire logic wake_resume_o
);
	// -----------------------------
	// mode relations
	// -----------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_temp_reads_one: assert property (psel_i && penable_i && !pwrite_i && paddr_i == 12'h000
		|-> prdata_o[6]) else $error("temp bit read zero");
	a_normal_halt_high: assert property (mode_o == `PMC_MODE_NORMAL
		|-> halt_n_o) else $error("halt low in normal");
	a_halt_pins_low: assert property (mode_o == `PMC_MODE_HALT
		|-> !halt_n_o && !status_output_o) else $error("halt pins high");
	a_halt_units_run: assert property (mode_o == `PMC_MODE_HALT |-> system_clock_output_en_o
		&& refresh_en_o && dma_clk_en_o && periph_clk_en_o) else $error("halt stopped unit");
	a_sleep_core_gated: assert property (mode_o == `PMC_MODE_SLEEP |-> !cpu_clk_en_o && !dma_clk_en_o
		&& !refresh_en_o && system_clock_output_en_o) else $error("sleep gating");
	a_sleep_bus_high: assert property (mode_o == `PMC_MODE_SLEEP && !bus_grant_o
		|-> force_bus_high_o && status_output_o && !halt_n_o) else $error("sleep bus state");
	a_sleep_fast_wake: assert property (mode_o == `PMC_MODE_SLEEP && $fell(nmi_n_i)
		|-> ##[1:8] mode_o == `PMC_MODE_NORMAL) else $error("slow sleep wake");
	a_idle_clock_off: assert property (mode_o == `PMC_MODE_IDLE && !bus_grant_o
		|-> !system_clock_output_en_o && !refresh_en_o && !cpu_clk_en_o) else $error("idle clk");
	a_idle_grant_slow: assert property (mode_o == `PMC_MODE_IDLE && $fell(bus_request_n_i)
		|-> !bus_grant_o [*8]) else $error("idle grant fast");
	a_standby_osc_off: assert property (mode_o == `PMC_MODE_STANDBY
		&& $past(mode_o) != `PMC_MODE_STANDBY |-> !osc_en_o) else $error("osc on in standby");
	a_wake_one_path: assert property (wake_service_o
		|-> !wake_resume_o ##1 !wake_service_o) else $error("wake pulse");
	c_idle_grant: cover property (mode_o == `PMC_MODE_IDLE ##1 bus_grant_o);
	c_service: cover property (wake_service_o);
	c_resume: cover property (wake_resume_o);
endmodule // pmc_power_mode_ctrl_sva
bind pmc_power_mode_ctrl pmc_power_mode_ctrl_sva chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .nmi_n_i(nmi_n_i), .bus_request_n_i(bus_request_n_i), .mode_o(mode_o),
	.halt_n_o(halt_n_o), .status_output_o(status_output_o), .force_bus_high_o(force_bus_high_o),
	.cpu_clk_en_o(cpu_clk_en_o), .dma_clk_en_o(dma_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
	.refresh_en_o(refresh_en_o), .system_clock_output_en_o(system_clock_output_en_o),
	.osc_en_o(osc_en_o), .bus_grant_o(bus_grant_o), .wake_service_o(wake_service_o),
	.wake_resume_o(wake_resume_o));
`default_nettype wire

/* File: test/pmc_power_mode_ctrl_tb.sv */
// bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_power_mode_ctrl_tb;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0000_0000, prd, r;
	logic [5:0] core = 6'h00; // fetch, int ack, nmi ack, io cycle, io read, t2
	logic [2:0] ext_en = 3'h0, want_irq = 3'h0, mode, irq_n, sfs;
	logic onchip = 1'b0, gflag = 1'b0, want_bus = 1'b0, want_nmi = 1'b0;
	logic pready, pslverr, halt_n, stat, fs_n, ioq_n, iord_n, grant, srv, rsm, nmi_n, breq_n;
	int n_fail = 0, checks_done = 0, cyc_cnt = 0, n_srv = 0, n_rsm = 0, n, s0, r0;
	logic [31:0] cc [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0008, 32'h0000_0040, 32'h0000_0048};
	logic [31:0] ic [5] = '{32'h0000_0000, 32'h0000_0020, 32'h0000_0020, 32'h0000_0020, 32'h0000_0020};
	logic [2:0] md [5] = '{`PMC_MODE_SLEEP, `PMC_MODE_SYSSTOP, `PMC_MODE_IDLE, `PMC_MODE_STANDBY,
		`PMC_MODE_STANDBY};
	int lim [5] = '{0, 0, 0, 100, 64};
	always #5 clk = ~clk;
	pmc_power_mode_ctrl #(.STBY_SLOW_CLKS(100)) dut_u (.core_clk_i(clk), .rst_n_i(rst_n),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.pready_o(pready), .prdata_o(prd), .pslverr_o(pslverr), .opcode_fetch_i(core[5]),
		.int_ack_i(core[4]), .nmi_ack_first_i(core[3]), .io_cycle_i(core[2]), .io_read_i(core[1]),
		.io_t2_i(core[0]), .nmi_n_i(nmi_n), .external_interrupt_request_n_i(irq_n),
		.bus_request_n_i(breq_n), .ext_int_enable_i(ext_en), .onchip_int_i(onchip),
		.global_interrupt_flag_i(gflag), .mode_o(mode), .halt_n_o(halt_n), .status_output_o(stat),
		.fetch_cycle_strobe_n_o(fs_n), .io_request_strobe_n_o(ioq_n), .io_read_strobe_n_o(iord_n),
		.force_bus_high_o(), .cpu_clk_en_o(), .dma_clk_en_o(), .periph_clk_en_o(),
		.refresh_en_o(), .system_clock_output_en_o(), .osc_en_o(), .bus_grant_o(grant),
		.wake_service_o(srv), .wake_resume_o(rsm));
	pmc_far_side far_u (.core_clk_i(clk), .want_bus_i(want_bus), .want_irq_i(want_irq),
		.want_nmi_i(want_nmi), .bus_request_n_o(breq_n), .irq_n_o(irq_n), .nmi_n_o(nmi_n));
	// -----------------------------
	// counters, timeout
	// -----------------------------
	always @(posedge clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		n_srv <= n_srv + (srv === 1'b1);
		n_rsm <= n_rsm + (rsm === 1'b1);
		if (cyc_cnt == 20000)
		begin
			n_fail++;
			summarize();
		end
	end
	// -----------------------------
	// tasks
	// -----------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// apb transfer: setup, access, hold until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prd;
		psel <= 1'b0; pen <= 1'b0;
	endtask
	// one core cycle, strobes sampled one clock later
	task automatic cyc(input logic [5:0] v);
		@(posedge clk);
		core <= v;
		@(posedge clk);
		core <= 6'h00;
		@(negedge clk);
		sfs = {fs_n, ioq_n, iord_n};
	endtask
	task automatic wait_mode(input logic [2:0] m, input int lim_c);
		n = 0;
		@(negedge clk);
		while (mode !== m && n < lim_c)
		begin
			@(negedge clk);
			n++;
		end
		check(mode, m);
	endtask
	// -----------------------------
	// scenarios
	// -----------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, `PMC_OFS_OPERATING_MODE, 32'h0000_0000);
		check(r, 32'h0000_00E0);
		apb(1'b0, 12'h014, 32'h0000_0000);
		check(r, 32'h0000_0000);
		apb(1'b1, `PMC_OFS_OPERATING_MODE, 32'h0000_0020);
		apb(1'b0, `PMC_OFS_OPERATING_MODE, 32'h0000_0000);
		check(r[6], 1'b1);
		cyc(6'h20);
		check(sfs[2], 1'b0);
		cyc(6'h20);
		check(sfs[2], 1'b1);
		cyc(6'h06);
		check(sfs[1:0], 2'h0);
		apb(1'b1, `PMC_OFS_OPERATING_MODE, 32'h0000_00C0);
		cyc(6'h10);
		check(sfs[2], 1'b0);
		cyc(6'h06);
		check(sfs[1:0], 2'h3);
		cyc(6'h07);
		check(sfs[1:0], 2'h0);
		apb(1'b1, `PMC_OFS_COMMAND, 32'h0000_0001);
		wait_mode(`PMC_MODE_HALT, 10);
		check({halt_n, stat}, 2'h0);
		want_nmi <= 1'b1;
		wait_mode(`PMC_MODE_NORMAL, 20);
		want_nmi <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b1, `PMC_OFS_COMMAND, 32'h0000_0002);
		wait_mode(`PMC_MODE_SLEEP, 10);
		want_nmi <= 1'b1;
		wait_mode(`PMC_MODE_NORMAL, 12);
		want_nmi <= 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, `PMC_OFS_CPU_CONTROL, cc[i]);
			apb(1'b1, `PMC_OFS_IO_CONTROL, ic[i]);
			apb(1'b1, `PMC_OFS_COMMAND, 32'h0000_0002);
			wait_mode(md[i], 10);
			ext_en <= 3'h0; want_irq <= 3'h1; onchip <= (i != 0);
			repeat (30) @(posedge clk);
			check(mode, md[i]);
			gflag <= i[0]; onchip <= 1'b0; s0 = n_srv; r0 = n_rsm;
			ext_en <= 3'h1;
			wait_mode(`PMC_MODE_NORMAL, 300);
			check(n >= lim[i], 1'b1);
			want_irq <= 3'h0; ext_en <= 3'h0;
			repeat (16) @(posedge clk);
			check(n_srv - s0, i[0]);
			check(n_rsm - r0, !i[0]);
		end
		apb(1'b1, `PMC_OFS_CPU_CONTROL, 32'h0000_0028);
		apb(1'b1, `PMC_OFS_COMMAND, 32'h0000_0002);
		wait_mode(`PMC_MODE_IDLE, 10);
		want_bus <= 1'b1;
		n = 0;
		while (grant !== 1'b1 && n < 60) begin @(negedge clk); n++; end
		check(grant, 1'b1);
		check(n >= 8, 1'b1);
		want_bus <= 1'b0;
		repeat (20) @(negedge clk);
		check({grant, mode}, {1'b0, `PMC_MODE_IDLE});
		want_nmi <= 1'b1;
		wait_mode(`PMC_MODE_NORMAL, 30);
		want_nmi <= 1'b0;
		repeat (16) @(posedge clk);
		apb(1'b1, `PMC_OFS_CPU_CONTROL, 32'h0000_0048);
		apb(1'b1, `PMC_OFS_COMMAND, 32'h0000_0002);
		wait_mode(`PMC_MODE_STANDBY, 10);
		ext_en <= 3'h1; want_irq <= 3'h1;
		repeat (10) @(posedge clk);
		want_irq <= 3'h0;
		repeat (100) @(negedge clk);
		check(mode, `PMC_MODE_STANDBY);
		want_nmi <= 1'b1;
		wait_mode(`PMC_MODE_NORMAL, 100);
		summarize();
	end
endmodule // pmc_power_mode_ctrl_tb
`default_nettype wire
